// ### src/timer_ctl_defs.vh
// Purpose: Offsets, field positions, reset values and codes for the timer control block
// Assumes: 16-bit register data, byte offsets within the module
// Notes:   Header only; definitions, no logic
`ifndef TIMER_CTL_DEFS_VH
`define TIMER_CTL_DEFS_VH

// Register offsets
`define OFS_CONTROL        12'h606
`define OFS_STATUS         12'h608
`define OFS_COMPARE        12'h610
`define OFS_PRELOAD        12'h60C

// Control register fields
`define CTL_RUN            15
`define CTL_IE_HI          14
`define CTL_IE_LO          12
`define CTL_GATE_EN        11
`define CTL_PRESC_SEL      10
`define CTL_CLK_EN         9
`define CTL_SRC_PIN        8
`define CTL_TAP_HI         7
`define CTL_TAP_LO         5
`define CTL_MODE_HI        4
`define CTL_MODE_LO        2
`define CTL_OACT_HI        1
`define CTL_OACT_LO        0
`define CTL_RESET          16'h0000

// Status register fields
`define ST_IRQ             15
`define ST_EXPIRY          14
`define ST_GATE            13
`define ST_MATCH           12
`define ST_GLEVEL          11
`define ST_ACTIVE          10
`define ST_OUT             9
`define ST_WINDOW          8

// Values
`define PRESC_ALL_ONES     8'hFF
`define COUNT_ZERO         16'h0000
`define COUNT_ONE          16'h0001
`define MODE_CAPCMP        3'h0
`define OACT_OFF           2'h0
`define OACT_TOGGLE        2'h1
`define OACT_ZERO          2'h2
`define OACT_ONE           2'h3

`endif

// ### src/timer_prescaler.v
// Purpose: 8-bit down-counting prescaler with tap edge detection
// Assumes: tick_in is a one-cycle pulse on each selected-clock falling edge
// Notes:   Loaded with all ones while held
`timescale 1ns/1ns
module timer_prescaler #(
	parameter WIDTH = 8
) (
	// Clock and control
	input  wire             clk_in,
	input  wire             rst_in,
	input  wire             ce_in,
	input  wire             hold_in,
	input  wire             tick_in,
	input  wire [2:0]       tap_sel_in,
	// Results
	output reg  [WIDTH-1:0] taps_out,
	output wire             tap_fall_out
);
	wire [WIDTH-1:0] taps_nxt;
	wire [WIDTH-1:0] falls;
	wire [2:0]       idx;

	assign taps_nxt = taps_out - {{(WIDTH-1){1'b0}}, 1'b1};
	// Tap falling edges
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_fall
			assign falls[g] = tick_in & taps_out[g] & ~taps_nxt[g];
		end
	endgenerate
	// Code n selects tap n-1 (divide by 2^n); code 0 the top tap
	assign idx = tap_sel_in - 3'h1;
	assign tap_fall_out = falls[idx];

	always @(posedge clk_in) begin
		if (rst_in || (ce_in && hold_in)) begin
			taps_out <= {WIDTH{1'b1}};
		end else if (ce_in && tick_in) begin
			taps_out <= taps_nxt;
		end
	end
endmodule // timer_prescaler

// ### src/timer_control_status.v
// Purpose: Control and status logic of a 16-bit down-counting timer with prescaler
// Assumes: Single clock; gate and input pins asynchronous; gate pin active low
// Notes:   Host stalls status refresh with stat_rd_in during a read
`timescale 1ns/1ns
`include "timer_ctl_defs.vh"
module timer_control_status #(
	parameter PRE_W = 8,
	parameter CNT_W = 16
) (
	// Clock, reset, enable
	input  wire             clk_in,
	input  wire             rst_in,
	input  wire             ce_in,
	// Register port
	input  wire             module_halt_in,
	input  wire             sel_in,
	input  wire             wr_in,
	input  wire [11:0]      addr_in,
	input  wire [15:0]      wdata_in,
	input  wire             stat_rd_in,
	output reg  [15:0]      rdata_out,
	output reg              ack_out,
	output reg              berr_out,
	// Pins
	input  wire             timer_input_pin_in,
	input  wire             gate_input_pin_n_in,
	output reg              timer_output_pin_out,
	output reg              timer_output_pin_oe_out,
	// Interrupt request
	output reg              irq_out
);
	// Registers
	reg  [15:0]      ctl_r;
	reg  [CNT_W-1:0] cmp_r;
	reg  [CNT_W-1:0] pre_r;
	reg  [CNT_W-1:0] cnt_r;
	reg              expiry_flag_r;
	reg              gate_event_flag_r;
	reg              match_event_flag_r;
	reg              match_window_flag_r;
	reg              out_r;
	reg              half_r;
	reg  [15:0]      stat_r;
	reg  [2:0]       tin_sync_r;
	reg  [2:0]       gate_sync_r;
	reg              tin_r;
	reg              gate_n_r;
	reg              gate_n_d_r;
	reg              sel_clk_d_r;

	// Control fields
	wire             run_enable         = ctl_r[`CTL_RUN];
	wire [2:0]       irq_source_enables = ctl_r[`CTL_IE_HI:`CTL_IE_LO];
	wire             gate_input_enable  = ctl_r[`CTL_GATE_EN];
	wire             presc_select       = ctl_r[`CTL_PRESC_SEL];
	wire             clock_enable_bit   = ctl_r[`CTL_CLK_EN];
	wire             src_pin            = ctl_r[`CTL_SRC_PIN];
	wire [2:0]       tap_select         = ctl_r[`CTL_TAP_HI:`CTL_TAP_LO];
	wire [2:0]       operating_field    = ctl_r[`CTL_MODE_HI:`CTL_MODE_LO];
	wire [1:0]       output_action      = ctl_r[`CTL_OACT_HI:`CTL_OACT_LO];

	wire             capcmp = (operating_field == `MODE_CAPCMP);
	wire             gate_ok;
	wire             active;
	wire             sel_clk;
	wire             tick;
	wire             tap_fall;
	wire             cnt_step;
	wire [CNT_W-1:0] cnt_dec;
	wire             timeout;
	wire             match;
	wire             gate_evt;
	wire             irq_any;
	wire [PRE_W-1:0] taps;
	wire             wr_ok;
	wire             wr_stat;
	wire [15:0]      stat_nxt;

	function hit;
		input [11:0] a;
		input [11:0] ofs;
		begin
			hit = sel_in && !module_halt_in && (a == ofs);
		end
	endfunction

	assign gate_ok = !gate_input_enable || capcmp || !gate_n_r;
	assign active  = run_enable && clock_enable_bit && gate_ok;
	assign sel_clk = src_pin ? tin_r : half_r;
	assign tick    = active && sel_clk_d_r && !sel_clk;
	assign cnt_step = presc_select ? tap_fall : tick;
	assign cnt_dec  = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
	assign timeout  = cnt_step && (cnt_r == `COUNT_ONE);
	assign match    = cnt_step && (cnt_dec == cmp_r);
	assign gate_evt = gate_input_enable && run_enable && !gate_n_d_r && gate_n_r;
	assign irq_any  = (expiry_flag_r & irq_source_enables[2])
	                | (gate_event_flag_r & irq_source_enables[1])
	                | (match_event_flag_r & irq_source_enables[0]);
	assign wr_ok    = wr_in && ce_in;
	assign wr_stat  = wr_ok && hit(addr_in, `OFS_STATUS);

	timer_prescaler #(
		.WIDTH      (PRE_W)
	) u_presc (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.ce_in       (ce_in),
		.hold_in     (!run_enable),
		.tick_in     (tick),
		.tap_sel_in  (tap_select),
		.taps_out    (taps),
		.tap_fall_out(tap_fall)
	);

	// sign bit is OR of enabled flags
	// gate level reads one when negated
	assign stat_nxt = {irq_any, expiry_flag_r, gate_event_flag_r, match_event_flag_r,
	                   gate_n_r, active, out_r, match_window_flag_r, taps};

	// Pin synchronisers
	always @(posedge clk_in) begin
		if (rst_in) begin
			tin_sync_r  <= 3'h0;
			gate_sync_r <= 3'h7;
			tin_r       <= 1'b0;
			gate_n_r    <= 1'b1;
			gate_n_d_r  <= 1'b1;
			sel_clk_d_r <= 1'b0;
			half_r      <= 1'b0;
		end else if (ce_in) begin
			tin_sync_r  <= {tin_sync_r[1:0], timer_input_pin_in};
			gate_sync_r <= {gate_sync_r[1:0], gate_input_pin_n_in};
			if (tin_sync_r[1] == tin_sync_r[2]) begin
				tin_r <= tin_sync_r[2];
			end
			if (gate_sync_r[1] == gate_sync_r[2]) begin
				gate_n_r <= gate_sync_r[2];
			end
			gate_n_d_r  <= gate_n_r;
			sel_clk_d_r <= sel_clk;
			half_r      <= ~half_r;
		end
	end

	// Control and compare registers
	always @(posedge clk_in) begin
		if (rst_in) begin
			ctl_r <= `CTL_RESET;
			cmp_r <= {CNT_W{1'b0}};
			pre_r <= {CNT_W{1'b0}};
		end else if (wr_ok) begin
			// host writes control at any time, running or stopped
			if (hit(addr_in, `OFS_CONTROL)) begin
				ctl_r <= wdata_in;
			end
			if (hit(addr_in, `OFS_COMPARE)) begin
				cmp_r <= wdata_in[CNT_W-1:0];
			end
			if (hit(addr_in, `OFS_PRELOAD)) begin
				pre_r <= wdata_in[CNT_W-1:0];
			end
		end
	end

	// Counter, flags and output
	always @(posedge clk_in) begin
		if (rst_in) begin
			cnt_r               <= `COUNT_ZERO;
			expiry_flag_r       <= 1'b0;
			gate_event_flag_r   <= 1'b0;
			match_event_flag_r  <= 1'b0;
			match_window_flag_r <= 1'b0;
			out_r               <= 1'b0;
		end else if (ce_in) begin
			if (wr_stat && wdata_in[`ST_EXPIRY]) begin
				expiry_flag_r <= 1'b0;
			end
			if (wr_stat && wdata_in[`ST_GATE]) begin
				gate_event_flag_r <= 1'b0;
			end
			if (wr_stat && wdata_in[`ST_MATCH]) begin
				match_event_flag_r <= 1'b0;
			end
			if (timeout) begin
				expiry_flag_r <= 1'b1;
			end
			if (gate_evt) begin
				gate_event_flag_r <= 1'b1;
			end
			if (match) begin
				match_event_flag_r <= 1'b1;
			end
			if (!run_enable) begin
				cnt_r               <= `COUNT_ZERO;
				match_window_flag_r <= 1'b0;
			end else begin
				if (cnt_step) begin
					cnt_r <= (cnt_r == `COUNT_ZERO) ? pre_r : cnt_dec;
				end
				if (timeout) begin
					match_window_flag_r <= 1'b0;
				end else if (match) begin
					match_window_flag_r <= 1'b1;
				end
			end
			case (output_action)
				`OACT_TOGGLE: begin
					if (!run_enable) begin
						out_r <= 1'b0;
					end else if (capcmp ? match : timeout) begin
						out_r <= ~out_r;
					end
				end
				`OACT_ZERO: begin
					if (!run_enable || timeout) begin
						out_r <= 1'b0;
					end else if (capcmp && match) begin
						out_r <= 1'b1;
					end
				end
				`OACT_ONE: begin
					if (!run_enable || timeout) begin
						out_r <= 1'b1;
					end else if (capcmp && match) begin
						out_r <= 1'b0;
					end
				end
				default: begin
					out_r <= out_r;
				end
			endcase
		end
	end

	// Status snapshot and bus answers
	always @(posedge clk_in) begin
		if (rst_in) begin
			stat_r                  <= {8'h00, `PRESC_ALL_ONES};
			rdata_out               <= 16'h0000;
			ack_out                 <= 1'b0;
			berr_out                <= 1'b0;
			irq_out                 <= 1'b0;
			timer_output_pin_out    <= 1'b0;
			timer_output_pin_oe_out <= 1'b0;
		end else if (ce_in) begin
			if (!stat_rd_in) begin
				stat_r <= stat_nxt;
			end
			ack_out  <= sel_in && !module_halt_in;
			berr_out <= sel_in && module_halt_in;
			if (hit(addr_in, `OFS_CONTROL)) begin
				rdata_out <= ctl_r;
			end else if (hit(addr_in, `OFS_STATUS)) begin
				rdata_out <= stat_r;
			end else if (hit(addr_in, `OFS_COMPARE)) begin
				rdata_out <= cmp_r;
			end else if (hit(addr_in, `OFS_PRELOAD)) begin
				rdata_out <= pre_r;
			end else begin
				rdata_out <= 16'h0000;
			end
			irq_out <= irq_any;
			timer_output_pin_oe_out <= (output_action != `OACT_OFF);
			timer_output_pin_out    <= out_r;
		end
	end
endmodule // timer_control_status

// ### sim/timer_ctl_chk.sv
// Purpose: Port checker for the timer control block
// Assumes: ce_in high in use
// Notes:   Mirrors control writes to know the programmed state
`timescale 1ns/1ns
module timer_ctl_chk (
	// Clock and reset
	input wire        clk_in,
	input wire        rst_in,
	input wire        ce_in,
	// Register port
	input wire        module_halt_in,
	input wire        sel_in,
	input wire        wr_in,
	input wire [11:0] addr_in,
	input wire [15:0] wdata_in,
	input wire [15:0] rdata_out,
	input wire        ack_out,
	input wire        berr_out,
	// Pins
	input wire        timer_output_pin_out,
	input wire        timer_output_pin_oe_out,
	input wire        irq_out
);
	reg  [15:0] ctl_r;
	reg         rds_r;
	reg  [1:0]  idle_r;
	wire        go = sel_in && ce_in && !module_halt_in;
	always @(posedge clk_in) begin
		if (rst_in) begin
			ctl_r <= 16'h0000;
			rds_r <= 1'b0;
			idle_r <= 2'h0;
		end else if (ce_in) begin
			if (go && wr_in && addr_in == 12'h606)
				ctl_r <= wdata_in;
			rds_r <= go && !wr_in && addr_in == 12'h608;
			idle_r <= ctl_r[15] ? 2'h0 : (idle_r == 2'h3 ? idle_r : idle_r + 2'h1);
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_ack; go |=> ack_out && !berr_out; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_berr; sel_in && ce_in && module_halt_in |=> berr_out && !ack_out; endproperty
	a_berr: assert property (p_berr) else $error("no bus error");
	property p_quiet; !sel_in |=> !ack_out && !berr_out; endproperty
	a_quiet: assert property (p_quiet) else $error("stray answer");
	property p_oe_off; (ctl_r[1:0] == 2'h0) [*2] |-> !timer_output_pin_oe_out; endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin driven");
	property p_oe_on; (ctl_r[1:0] != 2'h0) [*2] |-> timer_output_pin_oe_out; endproperty
	a_oe_on: assert property (p_oe_on) else $error("pin not driven");
	property p_lo;
		(!ctl_r[15] && (ctl_r[1:0] == 2'h1 || ctl_r[1:0] == 2'h2)) [*3] |-> !timer_output_pin_out;
	endproperty
	a_lo: assert property (p_lo) else $error("pin not low");
	property p_hi; (!ctl_r[15] && ctl_r[1:0] == 2'h3) [*3] |-> timer_output_pin_out; endproperty
	a_hi: assert property (p_hi) else $error("pin not high");
	property p_mask; (ctl_r[14:12] == 3'h0) [*3] |-> !irq_out; endproperty
	a_mask: assert property (p_mask) else $error("masked request");
	property p_idle_st;
		rds_r && ack_out && idle_r == 2'h3 |-> rdata_out[7:0] == 8'hFF && !rdata_out[10] && !rdata_out[8];
	endproperty
	a_idle_st: assert property (p_idle_st) else $error("idle status");
	property p_rst; disable iff (1'b0) rst_in |=> !irq_out && !ack_out && !timer_output_pin_oe_out;
	endproperty
	a_rst: assert property (p_rst) else $error("reset outputs");
	c_wr: cover property (go && wr_in && addr_in == 12'h606);
	c_berr: cover property (berr_out);
	c_irq: cover property ($rose(irq_out));
endmodule // timer_ctl_chk

bind timer_control_status timer_ctl_chk chk_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
	.module_halt_in(module_halt_in), .sel_in(sel_in), .wr_in(wr_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .rdata_out(rdata_out), .ack_out(ack_out), .berr_out(berr_out),
	.timer_output_pin_out(timer_output_pin_out),
	.timer_output_pin_oe_out(timer_output_pin_oe_out), .irq_out(irq_out));

// ### sim/imb_host.sv
// Purpose: Host core model on the register port
// Assumes: One select cycle per access
// Notes:   Address and data show inverted values when idle
`timescale 1ns/1ns
module imb_host (
	// Clock
	input  wire        clk_in,
	// Request
	output reg         sel_out = 1'b0,
	output reg         wr_out = 1'b0,
	output reg  [11:0] addr_out = 12'h000,
	output reg  [15:0] wdata_out = 16'h0000,
	output reg         stat_rd_out = 1'b0,
	// Answer
	input  wire [15:0] rdata_in,
	input  wire        ack_in,
	input  wire        berr_in
);
	task acc(input w, input [11:0] a, input [15:0] d, output [15:0] q, output [1:0] r);
		@(negedge clk_in);
		sel_out = 1'b1;
		wr_out = w;
		addr_out = a;
		wdata_out = d;
		stat_rd_out = !w && a == 12'h608;
		@(negedge clk_in);
		q = rdata_in;
		r = {berr_in, ack_in};
		sel_out = 1'b0;
		wr_out = 1'b0;
		stat_rd_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
endmodule // imb_host

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the timer control block
// Assumes: Gate pin is synchronised within a few cycles
// Notes:   Model keeps control and flag state
`timescale 1ns/1ns
module tb_top;
	reg         clk_in = 1'b0;
	reg         rst_in = 1'b1;
	reg         halt = 1'b0;
	reg         ce = 1'b1;
	reg         gate_n = 1'b1;
	reg  [31:0] seed = 32'h4E97;
	reg  [31:0] ps = 32'h4E97;
	reg  [15:0] q, m_ctl;
	reg  [1:0]  r;
	reg  [2:0]  m_fl;
	wire        sel, wr, srd, ack, berr, pin, oe, irq;
	wire [11:0] addr;
	wire [15:0] wd, rd_q;
	integer     n_fail = 0;
	integer     checked = 0;
	integer     i, k;
	timer_control_status dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
		.module_halt_in(halt), .sel_in(sel), .wr_in(wr), .addr_in(addr), .wdata_in(wd),
		.stat_rd_in(srd), .rdata_out(rd_q), .ack_out(ack), .berr_out(berr),
		.timer_input_pin_in(ps[0]), .gate_input_pin_n_in(gate_n),
		.timer_output_pin_out(pin), .timer_output_pin_oe_out(oe), .irq_out(irq));
	imb_host host_u (.clk_in(clk_in), .sel_out(sel), .wr_out(wr), .addr_out(addr),
		.wdata_out(wd), .stat_rd_out(srd), .rdata_in(rd_q), .ack_in(ack), .berr_in(berr));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [15:0] exp_st;
		exp_st = {|(m_ctl[14:12] & m_fl), m_fl, gate_n,
			m_ctl[15] & m_ctl[9] & (!m_ctl[11] | m_ctl[4:2] == 3'h0 | !gate_n),
			m_ctl[1:0] == 2'h3, 1'b0, 8'hFF};
	endfunction
	task chk(input [15:0] got, input [15:0] exp, input [15:0] msk);
		checked = checked + 1;
		if ((got & msk) !== (exp & msk)) begin
			n_fail = n_fail + 1;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr_reg(input [11:0] a, input [15:0] d);
		host_u.acc(1'b1, a, d, q, r);
		chk({14'h0, r}, 16'h0001, 16'h0003);
	endtask
	task rd(input [11:0] a);
		host_u.acc(1'b0, a, 16'h0000, q, r);
		chk({14'h0, r}, 16'h0001, 16'h0003);
	endtask
	task set_ctl(input [15:0] d);
		// stop first, then change fields, then start
		wr_reg(12'h606, m_ctl & 16'h7FFF);
		wr_reg(12'h606, d & 16'h7FFF);
		wr_reg(12'h606, d);
		m_ctl = d;
	endtask
	task st(input [15:0] msk);
		rd(12'h608);
		chk(q, exp_st(), msk);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial forever #4 clk_in = ~clk_in;
	always @(negedge clk_in) ps <= lfsr(ps);
	initial begin
		repeat (30000) @(posedge clk_in);
		n_fail = n_fail + 1;
		$display("BAD %0t watchdog", $time);
		complete_run;
	end
	initial begin
		m_fl = 3'h0;
		m_ctl = 16'h0000;
		repeat (12) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (6) @(negedge clk_in);
		st(16'hFFFF);
		for (i = 0; i < 8; i = i + 1) begin
			seed = lfsr(seed);
			set_ctl({1'b0, seed[14:5], i[2:0], seed[1:0]});
			rd(12'h606);
			chk(q, m_ctl, 16'hFFFF);
			repeat (3) @(negedge clk_in);
			chk({15'h0, oe}, {15'h0, m_ctl[1:0] != 2'h0}, 16'h0001);
			chk({15'h0, pin}, {15'h0, m_ctl[1:0] == 2'h3}, {15'h0, oe});
		end
		$display("test 1 done");
		wr_reg(12'h60C, 16'h0004);
		wr_reg(12'h610, 16'h0002);
		for (i = 0; i < 8; i = i + 1) begin
			set_ctl({1'b1, i[2:0], 12'h205 | (i[0] ? 12'h420 : 12'h000) | (i[1] ? 12'h100 : 12'h000)});
			q = 16'h0000;
			for (k = 0; k < 150 && !q[14]; k = k + 1)
				rd(12'h608);
			m_fl = 3'b101;
			st(16'hFC00);
			chk({15'h0, irq}, {15'h0, |(i[2:0] & 3'b101)}, 16'h0001);
			set_ctl(m_ctl & 16'h7FFF);
			repeat (3) @(negedge clk_in);
			st(16'hFFFF);
			wr_reg(12'h608, 16'h0000);
			st(16'hFFFF);
			wr_reg(12'h608, 16'h7000);
			m_fl = 3'b000;
			st(16'hFFFF);
			chk({15'h0, irq}, 16'h0000, 16'h0001);
		end
		// Capture/compare, zero action: high from match until timeout
		wr_reg(12'h60C, 16'h0040);
		wr_reg(12'h610, 16'h0020);
		set_ctl(16'h8202);
		rd(12'h608);
		for (k = 0; k < 150 && !q[9]; k = k + 1)
			rd(12'h608);
		chk(q, 16'h1F00, 16'hFF00);
		chk({14'h0, oe, pin}, 16'h0003, 16'h0003);
		for (k = 0; k < 150 && q[9]; k = k + 1)
			rd(12'h608);
		chk(q, 16'h5C00, 16'hFF00);
		chk({14'h0, oe, pin}, 16'h0002, 16'h0003);
		set_ctl(16'h0000);
		wr_reg(12'h608, 16'h7000);
		st(16'hFFFF);
		$display("test 2 done");
		set_ctl(16'hAA05);
		repeat (6) @(negedge clk_in);
		st(16'hFC00);
		gate_n = 1'b0;
		repeat (6) @(negedge clk_in);
		st(16'hAC00);
		gate_n = 1'b1;
		repeat (6) @(negedge clk_in);
		m_fl = 3'b010;
		st(16'hAC00);
		chk({15'h0, irq}, 16'h0001, 16'h0001);
		set_ctl(16'h0000);
		wr_reg(12'h608, 16'h7000);
		m_fl = 3'b000;
		$display("test 3 done");
		// Clock enable low: access neither taken nor answered
		@(negedge clk_in);
		ce = 1'b0;
		host_u.acc(1'b1, 12'h606, 16'h0003, q, r);
		chk({14'h0, r}, 16'h0000, 16'h0003);
		ce = 1'b1;
		halt = 1'b1;
		host_u.acc(1'b1, 12'h606, 16'h0003, q, r);
		chk({14'h0, r}, 16'h0002, 16'h0003);
		halt = 1'b0;
		rd(12'h606);
		chk(q, 16'h0000, 16'hFFFF);
		rd(12'h602);
		chk(q, 16'h0000, 16'hFFFF);
		wr_reg(12'h608, 16'h0FFF);
		st(16'hFDFF);
		$display("test 4 done");
		complete_run;
	end
endmodule // tb_top
